/* src/vtci_cfg.svh */
// Purpose: constants of the vlan tag classify/insert/strip block
// Assumes: byte-wide frames that end in a 4-byte fcs
// Notes: the package and the top module include this
`ifndef VTCI_CFG_SVH
`define VTCI_CFG_SVH

`define VTCI_PORT_W      3
`define VTCI_TPID        16'h8100
`define VTCI_TPID_HI     8'h81
`define VTCI_TPID_LO     8'h00
`define VTCI_DEF_VID     12'h001
`define VTCI_VID_NONE    12'h000
`define VTCI_VID_RSVD    12'hfff
`define VTCI_VID_SPACE   4096
`define VTCI_MAX_VLANS   9'h0ff
`define VTCI_RST_NVLAN   9'h001
`define VTCI_MAC_END     5'h0b
`define VTCI_TAG_END     5'h0f
`define VTCI_HDR_END     5'h0f
`define VTCI_TAG_POS     4'hc
`define VTCI_DLY_FULL    3'h4
`define VTCI_FCS_END     5'h03
`define VTCI_CRC_INIT    32'hffffffff
`define VTCI_CRC_POLY    32'hedb88320
`define VTCI_PORT_BASE   16'h0000
`define VTCI_STATUS_ADDR 16'h0100
`define VTCI_VLAN_PAGE   2'h1
`define VTCI_TAGOUT_BIT  12

`endif

/* src/vtci_pkg.sv */
// Purpose: types of the vlan tag classify/insert/strip block
// Assumes: vtci_cfg.svh gives the widths
// Notes: none
`include "vtci_cfg.svh"
package vtci_pkg;
    typedef enum logic [2:0] {S_HDR, S_DEC, S_EMIT, S_BODY, S_DROP, S_FCS} vtci_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } vtci_beat_t;

    typedef struct packed {
        logic [7:0]              data;
        logic                    last;
        logic [`VTCI_PORT_W-1:0] port;
    } vtci_obeat_t;
endpackage

/* src/vtci_top.sv */
// Purpose: per-frame vlan classify, egress filter, tag insert/strip, fcs rebuild
// Assumes: upstream gives one egress port per frame copy; flooding replicates upstream
// Notes: output passes through a shift-register fifo so all outputs are flops
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "vtci_cfg.svh"

module vtci_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  room2,
    // drain side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [DEPTH-1:0]            vld;
    } vtci_fifo_st_t;

    vtci_fifo_st_t q;
    vtci_fifo_st_t d;

    if (DEPTH < 2 || WIDTH < 1) begin : g_chk
        $error("vtci_fifo needs DEPTH >= 2 and WIDTH >= 1");
    end

    always_comb begin
        logic pushed;
        pushed = 1'b0;
        d = q;
        // head at slot 0, entries stay packed toward it
        if (out_ready && q.vld[0]) begin
            d.mem = q.mem >> WIDTH;
            d.vld = q.vld >> 1;
        end
        if (in_valid && !q.vld[DEPTH-1]) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (!pushed && !d.vld[i]) begin
                    d.mem[i] = in_data;
                    d.vld[i] = 1'b1;
                    pushed   = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign in_ready  = !q.vld[DEPTH-1];
    assign room2     = !q.vld[DEPTH-2];
    assign out_valid = q.vld[0];
    assign out_data  = q.mem[0];
endmodule

module vtci_top #(
    parameter int NPORTS     = 8,
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    reset,
    // ingress frame bytes
    input  wire logic                    in_valid,
    input  wire vtci_pkg::vtci_beat_t    in_beat,
    input  wire logic [`VTCI_PORT_W-1:0] in_port,
    input  wire logic [`VTCI_PORT_W-1:0] in_egr,
    output logic                         in_ready,
    // egress frame bytes
    output logic                         out_valid,
    output vtci_pkg::vtci_obeat_t        out_beat,
    input  wire logic                    out_ready,
    // register port
    input  wire logic [15:0]             reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [31:0]                  reg_rdata
);
    localparam int LP = `VTCI_PORT_W;

    typedef struct packed {
        vtci_pkg::vtci_state_t  st;
        logic [4:0]             cnt;
        logic [15:0][7:0]       hdr;
        logic [2:0]             fill;
        logic [31:0]            crc;
        logic                   tag_in;
        logic                   tag_out;
        logic [11:0]            vid;
        logic [15:0]            tci;
        logic [LP-1:0]          src;
        logic [LP-1:0]          egr;
        logic                   in_rdy;
        logic [NPORTS-1:0][11:0] pvid;
        logic [NPORTS-1:0]      tagp;
        logic [8:0]             nvlan;
        logic [15:0]            drops;
        logic [31:0]            rdata;
    } vtci_regs_t;

    if (NPORTS < 1 || NPORTS > (1 << LP) || FIFO_DEPTH < 2) begin : g_chk
        $error("vtci_top: NPORTS must fit the port field, FIFO_DEPTH >= 2");
    end

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h000000, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `VTCI_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    vtci_regs_t            q;
    vtci_regs_t            d;
    logic [NPORTS-1:0]     vmask [`VTCI_VID_SPACE];
    logic                  acc;
    logic                  push;
    logic [7:0]            pbyte;
    logic                  plast;
    logic                  fifo_rdy;
    logic                  fifo_room2;
    logic                  tpid_hit;
    logic [11:0]           tag_vid;
    logic [11:0]           cls_vid;
    logic                  fwd_ok;
    logic [7:0]            emit_byte;
    logic [4:0]            emit_end;
    logic [31:0]           fcs;
    logic                  is_port;
    logic                  is_vlan;
    logic                  is_stat;
    logic [LP-1:0]         pidx;
    logic [11:0]           rvid;
    logic [NPORTS-1:0]     wmask;
    logic                  creating;
    logic                  deleting;
    logic                  tbl_we;
    logic [11:0]           tbl_vid;
    logic [NPORTS-1:0]     tbl_mask;
    logic                  def_clr;
    vtci_pkg::vtci_obeat_t pbeat;

    ////////////////////////////////////////////////////////////////////////
    // classification and header helpers

    assign tpid_hit = {q.hdr[12], q.hdr[13]} == `VTCI_TPID;
    assign tag_vid  = {q.hdr[14][3:0], q.hdr[15]};
    // priority-tagged frames (vid 0) fall back to the port pvid
    assign cls_vid  = (tpid_hit && tag_vid != `VTCI_VID_NONE) ? tag_vid : q.pvid[q.src];
    assign fwd_ok   = vmask[cls_vid][q.egr] && cls_vid != `VTCI_VID_RSVD;
    assign emit_end = q.tag_out ? `VTCI_TAG_END : `VTCI_MAC_END;
    assign fcs      = ~q.crc;

    always_comb begin
        if (q.cnt <= `VTCI_MAC_END) begin
            emit_byte = q.hdr[q.cnt[3:0]];
        end else begin
            // tag sits between source mac and original type
            case (q.cnt[1:0])
                2'h0:    emit_byte = `VTCI_TPID_HI;
                2'h1:    emit_byte = `VTCI_TPID_LO;
                2'h2:    emit_byte = q.tci[15:8];
                default: emit_byte = q.tci[7:0];
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register decode

    assign is_port  = reg_addr >= `VTCI_PORT_BASE && reg_addr[1:0] == 2'h0
                      && reg_addr < `VTCI_PORT_BASE + 16'(4 * NPORTS);
    assign is_vlan  = reg_addr[15:14] == `VTCI_VLAN_PAGE && reg_addr[1:0] == 2'h0;
    assign is_stat  = reg_addr == `VTCI_STATUS_ADDR;
    assign pidx     = LP'((reg_addr - `VTCI_PORT_BASE) >> 2);
    assign rvid     = reg_addr[13:2];
    assign wmask    = reg_wdata[NPORTS-1:0];
    assign creating = vmask[rvid] == '0 && wmask != '0 && rvid != `VTCI_DEF_VID;
    assign deleting = vmask[rvid] != '0 && wmask == '0 && rvid != `VTCI_DEF_VID;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d        = q;
        acc      = in_valid && q.in_rdy;
        push     = 1'b0;
        pbyte    = 8'h00;
        plast    = 1'b0;
        tbl_we   = 1'b0;
        tbl_vid  = `VTCI_VID_NONE;
        tbl_mask = '0;
        def_clr  = 1'b0;
        d.rdata  = 32'h00000000;
        case (q.st)
            vtci_pkg::S_HDR: begin
                if (acc) begin
                    d.hdr[q.cnt[3:0]] = in_beat.data;
                    if (q.cnt == 5'h00) begin
                        d.src = in_port;
                        d.egr = in_egr;
                    end
                    // runt without a full header is swallowed
                    if (in_beat.last) begin
                        d.cnt   = 5'h00;
                        d.drops = q.drops + 16'h0001;
                    end else if (q.cnt == `VTCI_HDR_END) begin
                        d.st  = vtci_pkg::S_DEC;
                        d.cnt = 5'h00;
                    end else begin
                        d.cnt = q.cnt + 5'h01;
                    end
                end
            end
            vtci_pkg::S_DEC: begin
                d.tag_in  = tpid_hit;
                d.vid     = cls_vid;
                d.tci     = {tpid_hit ? q.hdr[14][7:4] : 4'h0, cls_vid};
                d.tag_out = q.tagp[q.egr];
                d.fill    = tpid_hit ? 3'h0 : `VTCI_DLY_FULL;
                d.crc     = `VTCI_CRC_INIT;
                if (fwd_ok) begin
                    d.st = vtci_pkg::S_EMIT;
                end else begin
                    d.st    = vtci_pkg::S_DROP;
                    d.drops = q.drops + 16'h0001;
                end
            end
            vtci_pkg::S_EMIT: begin
                if (fifo_rdy) begin
                    push  = 1'b1;
                    pbyte = emit_byte;
                    d.crc = crc_byte(q.crc, emit_byte);
                    if (q.cnt == emit_end) begin
                        d.st  = vtci_pkg::S_BODY;
                        d.cnt = 5'h00;
                    end else begin
                        d.cnt = q.cnt + 5'h01;
                    end
                end
            end
            vtci_pkg::S_BODY: begin
                // hdr[12..15] is a 4-byte delay line that holds back the old fcs
                if (acc) begin
                    if (q.fill == `VTCI_DLY_FULL) begin
                        push         = 1'b1;
                        pbyte        = q.hdr[12];
                        d.crc        = crc_byte(q.crc, q.hdr[12]);
                        d.hdr[14:12] = q.hdr[15:13];
                        d.hdr[15]    = in_beat.data;
                    end else begin
                        d.hdr[`VTCI_TAG_POS + {1'b0, q.fill}] = in_beat.data;
                        d.fill = q.fill + 3'h1;
                    end
                    if (in_beat.last) begin
                        d.st  = vtci_pkg::S_FCS;
                        d.cnt = 5'h00;
                    end
                end
            end
            vtci_pkg::S_DROP: begin
                if (acc && in_beat.last) begin
                    d.st  = vtci_pkg::S_HDR;
                    d.cnt = 5'h00;
                end
            end
            vtci_pkg::S_FCS: begin
                if (fifo_rdy) begin
                    push  = 1'b1;
                    pbyte = fcs[{q.cnt[1:0], 3'h0} +: 8];
                    plast = q.cnt == `VTCI_FCS_END;
                    if (plast) begin
                        d.st  = vtci_pkg::S_HDR;
                        d.cnt = 5'h00;
                    end else begin
                        d.cnt = q.cnt + 5'h01;
                    end
                end
            end
            default: begin
                d.st  = vtci_pkg::S_HDR;
                d.cnt = 5'h00;
            end
        endcase
        // registered ready: two free slots now leave one next cycle
        d.in_rdy = fifo_room2 && (d.st == vtci_pkg::S_HDR || d.st == vtci_pkg::S_BODY
                                  || d.st == vtci_pkg::S_DROP);

        if (reg_wr && is_port) begin
            d.pvid[pidx] = reg_wdata[11:0];
            d.tagp[pidx] = reg_wdata[`VTCI_TAGOUT_BIT];
        end
        if (reg_wr && is_vlan && rvid != `VTCI_VID_NONE && rvid != `VTCI_VID_RSVD) begin
            if (!(creating && q.nvlan == `VTCI_MAX_VLANS)) begin
                tbl_we   = 1'b1;
                tbl_vid  = rvid;
                tbl_mask = wmask;
                def_clr  = creating;
                d.nvlan  = 9'(q.nvlan + {8'h00, creating} - {8'h00, deleting});
            end
        end
        if (reg_rd) begin
            if (is_port) begin
                d.rdata = {19'h00000, q.tagp[pidx], q.pvid[pidx]};
            end else if (is_vlan) begin
                d.rdata = 32'(vmask[rvid]);
            end else if (is_stat) begin
                d.rdata = {q.drops, 7'h00, q.nvlan};
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            q       <= '0;
            q.st    <= vtci_pkg::S_HDR;
            q.crc   <= `VTCI_CRC_INIT;
            q.pvid  <= {NPORTS{`VTCI_DEF_VID}};
            q.nvlan <= `VTCI_RST_NVLAN;
        end else begin
            q <= d;
        end
    end

    // vlan membership table, one port mask per vid
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int v = 0; v < `VTCI_VID_SPACE; v++) begin
                vmask[v] <= (v == `VTCI_DEF_VID) ? '1 : '0;
            end
        end else begin
            if (tbl_we) begin
                vmask[tbl_vid] <= tbl_mask;
            end
            if (def_clr) begin
                vmask[`VTCI_DEF_VID] <= vmask[`VTCI_DEF_VID] & ~tbl_mask;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output buffer and ports

    assign pbeat = '{data: pbyte, last: plast, port: q.egr};

    vtci_fifo #(
        .WIDTH ($bits(vtci_pkg::vtci_obeat_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (mclk),
        .reset     (reset),
        .in_valid  (push),
        .in_data   (pbeat),
        .in_ready  (fifo_rdy),
        .room2     (fifo_room2),
        .out_valid (out_valid),
        .out_data  (out_beat),
        .out_ready (out_ready)
    );

    assign in_ready  = q.in_rdy;
    assign reg_rdata = q.rdata;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    sequence s_dec_tagged;
        q.st == vtci_pkg::S_DEC && tpid_hit && tag_vid != `VTCI_VID_NONE;
    endsequence

    sequence s_dec_untagged;
        q.st == vtci_pkg::S_DEC && !tpid_hit && !reg_wr;
    endsequence

    a_tag_detect: assert property (
        q.st == vtci_pkg::S_DEC |=> q.tag_in == ({q.hdr[12], q.hdr[13]} == `VTCI_TPID))
        else $error("tag presence not taken from type field");
    a_tagged_vid: assert property (
        s_dec_tagged |=> q.vid == {q.hdr[14][3:0], q.hdr[15]} && q.tci[15:12] == q.hdr[14][7:4])
        else $error("tagged frame not classified by its vid");
    a_untagged_pvid: assert property (
        s_dec_untagged |=> q.vid == q.pvid[q.src] && q.tci[15:12] == 4'h0)
        else $error("untagged frame not classified by pvid");
    a_nonmember_drop: assert property (
        q.st == vtci_pkg::S_DEC && !fwd_ok |=> q.st == vtci_pkg::S_DROP ##0 !push)
        else $error("frame sent to port outside its vlan");
    a_tag_place: assert property (
        q.st == vtci_pkg::S_EMIT && q.tag_out && push && q.cnt == {1'b0, `VTCI_TAG_POS} |-> pbyte == `VTCI_TPID_HI)
        else $error("tag not placed after source mac");
    a_hdr_length: assert property (
        q.st == vtci_pkg::S_EMIT && push && q.cnt == emit_end
        |=> q.st == vtci_pkg::S_BODY && q.fill == (q.tag_in ? 3'h0 : `VTCI_DLY_FULL))
        else $error("header length wrong after insert or strip");
    a_strip_only: assert property (
        q.st == vtci_pkg::S_EMIT && !q.tag_out |-> q.cnt <= `VTCI_MAC_END)
        else $error("untagging port emitted tag bytes");
    a_fcs_entry: assert property (
        q.st == vtci_pkg::S_BODY && acc && in_beat.last |=> q.st == vtci_pkg::S_FCS && q.cnt == 5'h00)
        else $error("old fcs not replaced at frame end");
    a_fcs_tail: assert property (
        push && plast |-> q.st == vtci_pkg::S_FCS && q.cnt == `VTCI_FCS_END)
        else $error("frame end not after four new fcs bytes");
    a_vlan_cap: assert property (
        q.nvlan <= `VTCI_MAX_VLANS)
        else $error("more than 255 vlans configured");
    a_vid_space: assert property (
        tbl_we |-> tbl_vid != `VTCI_VID_NONE && tbl_vid != `VTCI_VID_RSVD)
        else $error("reserved vid written to table");
    a_default_prune: assert property (
        def_clr |=> (vmask[`VTCI_DEF_VID] & $past(tbl_mask)) == '0)
        else $error("new vlan members left in factory_vlan_group");
endmodule

/* tb/tb.sv */
// Purpose: self-checking bench of the vlan tag block
// Assumes: frames carry a 4-byte fcs, one egress copy each
// Notes: expected frames built by bench functions
`timescale 1ns/1ps
module tb;
    typedef logic [7:0] vtci_bq_t[$];
    typedef struct packed {
        logic [2:0]  p;
        logic [2:0]  e;
        logic        tg;
        logic [15:0] w;
        logic        go;
        logic        to;
        logic [15:0] ins;
    } vtci_case_t;

    logic                  mclk, reset, in_valid, in_ready, out_valid, out_ready;
    logic                  reg_wr, reg_rd, slow;
    vtci_pkg::vtci_beat_t  in_beat;
    vtci_pkg::vtci_obeat_t out_beat;
    logic [2:0]            in_port, in_egr;
    logic [15:0]           reg_addr;
    logic [31:0]           reg_wdata, reg_rdata;
    int                    miscompares, samples_checked;
    vtci_case_t            cases [10] = '{
        '{0, 1, 0, 16'h0800, 1, 0, 16'h0}, '{0, 2, 0, 16'h0800, 1, 1, 16'h0001},
        '{3, 4, 0, 16'h0800, 1, 0, 16'h0}, '{3, 1, 0, 16'h0800, 0, 0, 16'h0},
        '{0, 4, 1, 16'ha005, 1, 0, 16'h0}, '{0, 2, 1, 16'hb005, 1, 1, 16'h0},
        '{0, 1, 0, 16'h8101, 1, 0, 16'h0}, '{3, 3, 1, 16'h6000, 1, 0, 16'h0},
        '{0, 7, 0, 16'h0800, 0, 0, 16'h0}, '{0, 1, 1, 16'h0fff, 0, 0, 16'h0}};

    vtci_top #(.NPORTS(8), .FIFO_DEPTH(8)) u_dut (.mclk(mclk), .reset(reset), .in_valid(in_valid),
        .in_beat(in_beat), .in_port(in_port), .in_egr(in_egr), .in_ready(in_ready), .out_valid(out_valid),
        .out_beat(out_beat), .out_ready(out_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    vtci_sink u_sink (.mclk(mclk), .reset(reset), .out_valid(out_valid), .out_beat(out_beat),
        .out_ready(out_ready), .slow(slow));

    always #2 mclk = ~mclk;

    ////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [15:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(negedge mclk);
        check(reg_rdata, exp);
    endtask

    function automatic vtci_bq_t add_fcs(input vtci_bq_t f);
        logic [31:0] c = 32'hffffffff;
        foreach (f[i]) begin
            c ^= 32'(f[i]);
            repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
        end
        c = ~c;
        for (int k = 0; k < 4; k++)
            f.push_back(c[8*k +: 8]);
        return f;
    endfunction

    function automatic vtci_bq_t mk(input vtci_case_t c, input int n);
        vtci_bq_t f;
        for (int i = 0; i < 12; i++)
            f.push_back(8'($urandom));
        if (c.tg)
            f = {f, 8'h81, 8'h00, c.w[15:8], c.w[7:0], 8'h08, 8'h00};
        else
            f = {f, c.w[15:8], c.w[7:0]};
        for (int i = 0; i < n; i++)
            f.push_back(8'($urandom));
        return f;
    endfunction

    // tag kept, inserted after source mac, or stripped
    function automatic vtci_bq_t xform(input vtci_case_t c, input vtci_bq_t f);
        if (c.tg && !c.to)
            f = {f[0:11], f[16:$]};
        if (!c.tg && c.to)
            f = {f[0:11], 8'h81, 8'h00, c.ins[15:8], c.ins[7:0], f[12:$]};
        return add_fcs(f);
    endfunction

    task automatic send(input vtci_case_t c, input vtci_bq_t f);
        foreach (f[i]) begin
            @(posedge mclk);
            in_valid <= 1'b1;
            in_beat  <= '{data: f[i], last: (i == f.size() - 1)};
            in_port  <= c.p;
            in_egr   <= c.e;
            do @(negedge mclk); while (in_ready !== 1'b1);
        end
    endtask

    task automatic run_cases(input bit rnd);
        vtci_bq_t              f, x;
        vtci_pkg::vtci_obeat_t exp[$];
        int                    base, w;
        base = u_sink.got.size();
        foreach (cases[k]) begin
            f = mk(cases[k], rnd ? $urandom_range(46, 90) : 46);
            x = xform(cases[k], f);
            for (int i = 0; i < x.size() && cases[k].go; i++)
                exp.push_back('{data: x[i], last: (i == x.size() - 1), port: cases[k].e});
            send(cases[k], add_fcs(f));
        end
        @(posedge mclk);
        in_valid <= 1'b0;
        w = 0;
        while (u_sink.got.size() < base + exp.size() && w < 8000) begin
            @(posedge mclk);
            w++;
        end
        check(32'(u_sink.got.size() - base), 32'(exp.size()));
        foreach (exp[i])
            check(32'(u_sink.got[base+i]), 32'(exp[i]));
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        mclk = 0;
        reset = 1;
        in_valid = 0;
        in_beat = '0;
        in_port = 0;
        in_egr = 0;
        reg_addr = 0;
        reg_wdata = 0;
        reg_wr = 0;
        reg_rd = 0;
        slow = 0;
        void'($urandom(36));
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        for (int p = 0; p < 8; p++)
            reg_read(16'(4 * p), 32'h1);
        reg_read(16'h4004, 32'hff);
        reg_read(16'h0100, 32'h1);
        reg_read(16'h4008, 32'h0);
        reg_read(16'h0102, 32'h0);
        $display("test reset_values done");
        reg_write(16'h0008, 32'h1001);
        reg_write(16'h000c, 32'h005);
        reg_write(16'h4014, 32'h18);
        reg_read(16'h4004, 32'he7);
        reg_write(16'h7ff8, 32'h80);
        reg_read(16'h7ff8, 32'h80);
        reg_write(16'h4014, 32'h3c);
        reg_read(16'h4004, 32'h67);
        reg_read(16'h000c, 32'h005);
        reg_read(16'h0100, 32'h3);
        reg_write(16'h4000, 32'h1);
        reg_write(16'h7ffc, 32'h1);
        reg_read(16'h4000, 32'h0);
        reg_read(16'h7ffc, 32'h0);
        for (int v = 16; v < 268; v++)
            reg_write(16'h4000 + 16'(4 * v), 32'h1);
        reg_write(16'h44b0, 32'h1);
        reg_read(16'h44b0, 32'h0);
        reg_read(16'h0100, 32'hff);
        reg_read(16'h4004, 32'h66);
        for (int v = 16; v < 268; v++)
            reg_write(16'h4000 + 16'(4 * v), 32'h0);
        reg_read(16'h0100, 32'h3);
        $display("test vlan_setup done");
        for (int pass = 0; pass < 2; pass++) begin
            slow <= pass[0];
            run_cases(pass[0]);
            $display("test frames pass %0d done", pass);
        end
        reg_read(16'h0100, 32'h00060003);
        report_and_stop();
    end

    // hang guard, far beyond two passes of frames
    initial begin
        repeat (60000) @(posedge mclk);
        miscompares++;
        report_and_stop();
    end
endmodule

/* tb/vtci_sink.sv */
// Purpose: far-side egress port model that takes frame bytes
// Assumes: slow high gives random back-pressure
// Notes: bytes kept in got for the bench
`timescale 1ns/1ps
module vtci_sink (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset,
    // egress stream
    input  wire logic                  out_valid,
    input  wire vtci_pkg::vtci_obeat_t out_beat,
    output logic                       out_ready,
    // pacing
    input  wire logic                  slow
);
    vtci_pkg::vtci_obeat_t got[$];

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            out_ready <= 1'b0;
        end else begin
            if (out_valid && out_ready) begin
                got.push_back(out_beat);
            end
            out_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
        end
    end
endmodule
